// File: common/adc_ctl_pkg.sv
`default_nettype none
package adc_ctl_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned APERTURE_NS   = 40;
  localparam int unsigned CONV_TIME_NS  = 4000;
  localparam int unsigned APERTURE_CYC  =
    (APERTURE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYC      =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 16;

  // ==========================================================
  // widths and pin lanes
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned ADDR_W   = 8;
  localparam logic [11:0] ALL_OE   = 12'hfff;
  localparam logic [11:0] LANE_OE  = 12'hff0;
  localparam logic [11:0] NONE_OE  = 12'h000;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] RESULT_OFS   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_SOFT_BIT = 1;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_DONE_BIT  = 0;
  localparam int unsigned IRQ_OVR_BIT   = 1;
  localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================
  // types
  typedef struct packed {
    logic bipolar_mode;
    logic justify_right;
    logic wide_format_select;
    logic select_gating_mode;
  } strap_t;

  typedef struct packed {
    logic start_convert_n;
    logic device_select_n;
    logic done_flag_enable_n;
    logic output_enable_n;
    logic upper_byte_select_n;
  } host_pins_t;

  typedef struct packed {
    logic busy;
    logic sample;
    logic done;
  } seq_out_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h1,
    S_APERT = 3'h2,
    S_CONV  = 3'h4
  } seq_state_t;
endpackage
`default_nettype wire

// File: hdl/conv_sequencer.sv
`default_nettype none
module conv_sequencer
  import adc_ctl_pkg::*;
#(
  parameter int unsigned AP_CYC = APERTURE_CYC,
  parameter int unsigned CV_CYC = CONV_CYC
) (
  // clock and reset
  input  wire logic     aclk,
  input  wire logic     aresetn,
  // control
  input  wire logic     start,
  output var  seq_out_t status
);
  localparam logic [CNT_W-1:0] AP_LOAD = CNT_W'(AP_CYC - 1);
  localparam logic [CNT_W-1:0] CV_LOAD = CNT_W'(CV_CYC - 1);
  localparam int samp_dly = AP_CYC + 1;
  // counted from the cycle after start, where busy is first seen
  localparam int done_dly = AP_CYC + CV_CYC;

  seq_state_t       state_r;
  logic [CNT_W-1:0] cnt_r;
  wire              cnt_zero_w = (cnt_r == '0);
  wire [CNT_W-1:0]  cnt_dec_w  = cnt_r - 1'b1;

  // ==========================================================
  // sequence: hold after aperture delay, then convert
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      cnt_r   <= '0;
      status  <= '0;
    end else begin
      status.sample <= 1'b0;
      status.done   <= 1'b0;
      case (state_r)
        S_IDLE: if (start) begin
          state_r     <= S_APERT;
          cnt_r       <= AP_LOAD;
          status.busy <= 1'b1;
        end
        S_APERT: if (cnt_zero_w) begin
          state_r       <= S_CONV;
          cnt_r         <= CV_LOAD;
          status.sample <= 1'b1;
        end else begin
          cnt_r <= cnt_dec_w;
        end
        S_CONV: if (cnt_zero_w) begin
          state_r     <= S_IDLE;
          status.busy <= 1'b0;
          status.done <= 1'b1;
        end else begin
          cnt_r <= cnt_dec_w;
        end
        default: begin
          state_r     <= S_IDLE;
          status.busy <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  samp_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> ##samp_dly status.sample)
    else $error("sample not taken at fixed delay after start");
  conv_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start |=> status.busy ##done_dly status.done)
    else $error("conversion did not end on time");
endmodule
`default_nettype wire

// File: hdl/adc_conversion_start_and_format_control.sv
`default_nettype none
// How it works
// - start_convert_n low requests a conversion, after select gating.
// - gating mode high: start, done flag and its enable need device select.
// - gating mode low: select ignored for start and done flag; done flag only pulls low.
// - wide format: whole result as one parallel word in one read.
// - narrow format: result as bytes on upper eight data pins.
// - every output pin is released when not enabled.
// - sample is taken a fixed delay after the start edge.
// - bipolar mode gives twos complement coding.
// - done flag low while converting, high when result complete.
// - done flag pin driven only while its enable is low.
// - upper byte select low gives high byte, high gives low byte.
// - justify right picks right or left alignment in sixteen bits.
module adc_conversion_start_and_format_control
  import adc_ctl_pkg::*;
#(
  parameter int unsigned AP_CYC = APERTURE_CYC,
  parameter int unsigned CV_CYC = CONV_CYC
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // host pins and straps
  input  wire host_pins_t          pins,
  input  wire strap_t              straps,
  // converter core
  input  wire logic [RESULT_W-1:0] raw_code,
  output logic                     sample_hold,
  // data and done pins
  output logic [RESULT_W-1:0]      data_out,
  output logic [RESULT_W-1:0]      data_oe,
  output logic                     done_out,
  output logic                     done_oe,
  // interrupt
  output logic                     irq
);
  seq_out_t            seq;
  logic                req_prev_r;
  logic                ctrl_en_r;
  logic                soft_go_r;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] data_out_r;
  logic [RESULT_W-1:0] data_oe_r;
  logic                done_out_r;
  logic                done_oe_r;
  logic                sample_r;
  logic [IRQ_W-1:0]    irq_stat_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic                irq_r;
  logic                awready_r;
  logic                wready_r;
  logic                aw_got_r;
  logic                w_got_r;
  logic [ADDR_W-1:0]   waddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                arready_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;

  // ==========================================================
  // start request gating
  wire sel_w    = ~pins.device_select_n;
  wire gating_w = straps.select_gating_mode;
  wire gate_w   = gating_w ? sel_w : 1'b1;
  wire req_w    = ~pins.start_convert_n & gate_w;
  wire edge_w   = req_w & ~req_prev_r;
  // a request held low restarts at once: continuous conversion
  wire start_w  = ~seq.busy & ((ctrl_en_r & req_w) | soft_go_r);
  wire ovr_w    = edge_w & seq.busy;

  conv_sequencer #(
    .AP_CYC (AP_CYC),
    .CV_CYC (CV_CYC)
  ) u_seq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (start_w),
    .status  (seq)
  );

  // ==========================================================
  // result coding
  wire [RESULT_W-1:0] coded_w = straps.bipolar_mode ?
    {~raw_code[RESULT_W-1], raw_code[RESULT_W-2:0]} : raw_code;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r   <= '0;
      req_prev_r <= 1'b0;
      sample_r   <= 1'b0;
    end else begin
      req_prev_r <= req_w;
      sample_r   <= seq.sample;
      if (seq.done) result_r <= coded_w;
    end
  end

  // ==========================================================
  // output formatting
  wire       rd_en_w = ~(pins.device_select_n | pins.output_enable_n);
  wire       wide_w  = straps.wide_format_select;
  wire       jr_w    = straps.justify_right;
  wire       lowb_w  = pins.upper_byte_select_n;
  wire [3:0] ext_w   = straps.bipolar_mode ? {4{result_r[11]}} : 4'h0;
  wire [7:0] r_hi_w  = {ext_w, result_r[11:8]};
  wire [7:0] r_lo_w  = result_r[7:0];
  wire [7:0] l_hi_w  = result_r[11:4];
  wire [7:0] l_lo_w  = {result_r[3:0], 4'h0};
  wire [7:0] rj_w    = lowb_w ? r_lo_w : r_hi_w;
  wire [7:0] lj_w    = lowb_w ? l_lo_w : l_hi_w;
  wire [7:0] byte_w  = jr_w ? rj_w : lj_w;
  // the low four pins carry nothing in byte mode and stay released
  wire [RESULT_W-1:0] data_nxt = wide_w ? result_r : {byte_w, 4'h0};
  wire [RESULT_W-1:0] oe_sel_w = wide_w ? ALL_OE : LANE_OE;
  wire [RESULT_W-1:0] oe_nxt   = rd_en_w ? oe_sel_w : NONE_OE;

  // open drain in asynchronous mode: only driven while pulling low
  wire en_w      = ~pins.done_flag_enable_n;
  wire d_oe_nxt  = gating_w ? (sel_w & en_w) : (en_w & seq.busy);
  wire d_out_nxt = gating_w ? ~seq.busy : 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out_r <= '0;
      data_oe_r  <= NONE_OE;
      done_out_r <= 1'b0;
      done_oe_r  <= 1'b0;
    end else begin
      data_out_r <= data_nxt;
      data_oe_r  <= oe_nxt;
      done_out_r <= d_out_nxt;
      done_oe_r  <= d_oe_nxt;
    end
  end

  // ==========================================================
  // axi4-lite write path
  wire aw_hs_w  = awvalid & awready_r;
  wire w_hs_w   = wvalid & wready_r;
  wire wr_go_w  = aw_got_r & w_got_r & ~bvalid_r;
  wire b_hs_w   = bvalid_r & bready;
  wire [ADDR_W-1:0] wa_w = {waddr_r[ADDR_W-1:2], 2'h0};
  wire wr_ctrl_w = wr_go_w & (wa_w == CTRL_OFS) & wstrb_r[0];
  wire wr_mask_w = wr_go_w & (wa_w == IRQ_MASK_OFS) & wstrb_r[0];
  wire wr_ok_w   = (wa_w == CTRL_OFS) | (wa_w == IRQ_MASK_OFS) |
                   (wa_w == STATUS_OFS) | (wa_w == RESULT_OFS) |
                   (wa_w == IRQ_STAT_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (aw_hs_w) begin
        awready_r <= 1'b0;
        aw_got_r  <= 1'b1;
        waddr_r   <= awaddr;
      end
      if (w_hs_w) begin
        wready_r <= 1'b0;
        w_got_r  <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (b_hs_w) begin
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
        aw_got_r  <= 1'b0;
        w_got_r   <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      ctrl_en_r  <= CTRL_EN_RST;
      soft_go_r  <= 1'b0;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      soft_go_r <= wr_ctrl_w & wdata_r[CTRL_SOFT_BIT];
      if (wr_ctrl_w) ctrl_en_r <= wdata_r[CTRL_EN_BIT];
      if (wr_mask_w) irq_mask_r <= wdata_r[IRQ_W-1:0];
      if (wr_go_w) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok_w ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs_w) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite read path
  wire ar_hs_w = arvalid & arready_r;
  wire r_hs_w  = rvalid_r & rready;
  wire [ADDR_W-1:0] ra_w = {araddr[ADDR_W-1:2], 2'h0};
  wire [31:0] ctrl_rd_w = {30'h0, 1'b0, ctrl_en_r};
  wire [31:0] stat_rd_w = {24'h0, straps, 2'h0, req_w, seq.busy};
  wire [31:0] res_rd_w  = {20'h0, result_r};
  wire [31:0] ist_rd_w  = {30'h0, irq_stat_r};
  wire [31:0] imk_rd_w  = {30'h0, irq_mask_r};
  wire hit_c_w = (ra_w == CTRL_OFS);
  wire hit_s_w = (ra_w == STATUS_OFS);
  wire hit_r_w = (ra_w == RESULT_OFS);
  wire hit_i_w = (ra_w == IRQ_STAT_OFS);
  wire hit_m_w = (ra_w == IRQ_MASK_OFS);
  wire rd_hit_w = hit_c_w | hit_s_w | hit_r_w | hit_i_w | hit_m_w;
  wire [31:0] rd_mux_w = hit_c_w ? ctrl_rd_w :
                         hit_s_w ? stat_rd_w :
                         hit_r_w ? res_rd_w  :
                         hit_i_w ? ist_rd_w  :
                         hit_m_w ? imk_rd_w  : 32'h0;
  wire rd_clr_w = ar_hs_w & hit_i_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (ar_hs_w) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux_w;
      rresp_r   <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
    end else if (r_hs_w) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // ==========================================================
  // interrupts: a new event beats a clearing read
  wire [IRQ_W-1:0] ev_w = {ovr_w, seq.done};

  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    always_ff @(posedge aclk) begin
      if (!aresetn) irq_stat_r[i] <= 1'b0;
      else if (ev_w[i]) irq_stat_r[i] <= 1'b1;
      else if (rd_clr_w) irq_stat_r[i] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_r <= 1'b0;
    else irq_r <= |(irq_stat_r & irq_mask_r);
  end

  // ==========================================================
  // outputs
  assign awready     = awready_r;
  assign wready      = wready_r;
  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign arready     = arready_r;
  assign rvalid      = rvalid_r;
  assign rdata       = rdata_r;
  assign rresp       = rresp_r;
  assign data_out    = data_out_r;
  assign data_oe     = data_oe_r;
  assign done_out    = done_out_r;
  assign done_oe     = done_oe_r;
  assign sample_hold = sample_r;
  assign irq         = irq_r;

  // ==========================================================
  // checks
  sync_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (gating_w && pins.device_select_n && !soft_go_r) |-> !start_w)
    else $error("start taken without device select");
  async_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!gating_w && !pins.start_convert_n && ctrl_en_r && !seq.busy)
    |-> start_w)
    else $error("asynchronous start ignored");
  open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!gating_w && done_oe_r) |-> !done_out_r)
    else $error("open drain done flag driven high");
  wide_word_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wide_w && rd_en_w) |=> (data_oe_r == ALL_OE &&
    data_out_r == $past(result_r)))
    else $error("parallel word not presented");
  byte_lane_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wide_w && rd_en_w) |=> (data_oe_r == LANE_OE))
    else $error("byte lane enable wrong");
  release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pins.device_select_n || pins.output_enable_n)
    |=> (data_oe_r == NONE_OE))
    else $error("data pins not released");
  twos_comp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq.done && straps.bipolar_mode) |=>
    (result_r[11] != $past(raw_code[11]) &&
    result_r[10:0] == $past(raw_code[10:0])))
    else $error("bipolar coding wrong");
  done_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (gating_w && sel_w && en_w) |=>
    (done_oe_r && done_out_r == !$past(seq.busy)))
    else $error("done flag does not follow conversion");
  done_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pins.done_flag_enable_n |=> !done_oe_r)
    else $error("done flag driven while disabled");
  high_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wide_w && !lowb_w && !jr_w && rd_en_w) |=>
    (data_out_r[11:4] == $past(result_r[11:4])))
    else $error("high byte wrong");
  left_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!wide_w && lowb_w && !jr_w && rd_en_w) |=>
    (data_out_r[11:4] == {$past(result_r[3:0]), 4'h0}))
    else $error("left justified low byte wrong");
endmodule
`default_nettype wire

// File: dv/host_model.sv
`default_nettype none
// ==========================================================
// host bus controller: pins, straps and resolved pin levels
module host_model
  import adc_ctl_pkg::*;
(
  // clock
  input  wire logic                aclk,
  // pins towards the device
  output var  host_pins_t          pins,
  output var  strap_t              straps,
  // device outputs
  input  wire logic [RESULT_W-1:0] data_out,
  input  wire logic [RESULT_W-1:0] data_oe,
  input  wire logic                done_out,
  input  wire logic                done_oe,
  // levels seen on the wires
  output wire logic [RESULT_W-1:0] data_w,
  output wire logic                done_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RESULT_W-1:0] last_r;
  logic                done_last_r;

  initial begin
    pins   = '1;
    straps = 4'b0011;
  end

  // a released line floats, so show the inverse of the last level
  always_ff @(posedge aclk) begin
    last_r      <= (data_oe & data_out) | (~data_oe & last_r);
    done_last_r <= done_oe ? done_out : done_last_r;
  end
  assign data_w = (data_oe & data_out) | (~data_oe & ~last_r);
  // open drain done flag needs the pull-up in async mode
  assign done_w = done_oe ? done_out :
                  (straps.select_gating_mode ? ~done_last_r : 1'b1);

  task automatic set_straps(input strap_t s);
    @(posedge aclk);
    straps <= s;
  endtask

  // select is settled before any start pulse that follows
  task automatic drive(input logic sel, input logic oe, input logic eoc,
                       input logic ube);
    @(posedge aclk);
    pins.device_select_n     <= sel;
    pins.output_enable_n     <= oe;
    pins.done_flag_enable_n  <= eoc;
    pins.upper_byte_select_n <= ube;
  endtask

  task automatic pulse_start();
    @(posedge aclk);
    pins.start_convert_n <= 1'b0;
    @(posedge aclk);
    pins.start_convert_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: dv/adc_conversion_start_and_format_control_tb.sv
`default_nettype none
module adc_conversion_start_and_format_control_tb
  import adc_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned AP_C = 1;
  localparam int unsigned CV_C = 5;
  typedef struct packed {
    strap_t      st;
    logic        ube;
    logic [11:0] raw;
    logic [11:0] d;
    logic [11:0] oe;
  } row_t;
  // straps are {bipolar, justify, wide, gating}
  localparam row_t ROWS [7] = '{
    {4'b0011, 1'b0, 12'h1a5, 12'h1a5, ALL_OE},
    {4'b1011, 1'b0, 12'h1a5, 12'h9a5, ALL_OE},
    {4'b0101, 1'b0, 12'h1a5, 12'h010, LANE_OE},
    {4'b0101, 1'b1, 12'h1a5, 12'ha50, LANE_OE},
    {4'b0001, 1'b0, 12'h7c3, 12'h7c0, LANE_OE},
    {4'b0001, 1'b1, 12'h7c3, 12'h300, LANE_OE},
    {4'b1101, 1'b0, 12'h1a5, 12'hf90, LANE_OE}};

  logic              aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_v;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp, resp_v;
  host_pins_t        pins;
  strap_t            straps;
  logic [11:0]       raw_code, data_out, data_oe, data_w;
  logic              sample_hold, done_out, done_oe, done_w, irq;
  int                err_total, n_tests;

  adc_conversion_start_and_format_control #(
    .AP_CYC(AP_C), .CV_CYC(CV_C)
  ) i_adc_conversion_start_and_format_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(pins),
    .straps(straps), .raw_code(raw_code), .sample_hold(sample_hold),
    .data_out(data_out), .data_oe(data_oe), .done_out(done_out),
    .done_oe(done_oe), .irq(irq));

  host_model i_host_model (
    .aclk(aclk), .pins(pins), .straps(straps), .data_out(data_out),
    .data_oe(data_oe), .done_out(done_out), .done_oe(done_oe),
    .data_w(data_w), .done_w(done_w));

  // ==========================================================
  // helpers
  task automatic chk_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, rd_v, resp_v);
    chk_val("register read", e, rd_v);
  endtask

  // one start pulse; run says whether a conversion must follow
  task automatic conv(input bit run);
    int n;
    i_host_model.pulse_start();
    for (n = 2; n < 12; n++) begin
      @(posedge aclk);
      #1;
      if (sample_hold === 1'b1) break;
    end
    chk_val("sample delay", run ? AP_C + 2 : 12, n);
    if (run) begin
      chk_bit("done busy", 1'b0, done_w);
      repeat (CV_C + 3) @(posedge aclk);
      #1;
      chk_bit("done idle", 1'b1, done_w);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d tests %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog and sequence
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    n_tests   = 0;
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, raw_code} = '0;
    wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk_val("reset ready", 2'b11, {awready, arready});
    chk_val("reset outs", 0, {bvalid, rvalid, data_oe, done_oe, irq});
    rd_chk(CTRL_OFS, 32'h1);
    rd_chk(IRQ_MASK_OFS, 32'h0);
    foreach (ROWS[i]) begin
      i_host_model.set_straps(ROWS[i].st);
      raw_code <= ROWS[i].raw;
      i_host_model.drive(1'b0, 1'b1, 1'b0, ROWS[i].ube);
      conv(1);
      i_host_model.drive(1'b0, 1'b0, 1'b0, ROWS[i].ube);
      repeat (2) @(posedge aclk);
      #1;
      chk_val("data", ROWS[i].d, data_out);
      chk_val("data oe", ROWS[i].oe, data_oe);
      chk_val("data pins", ROWS[i].d[11:4], data_w[11:4]);
      rd_chk(RESULT_OFS, ROWS[i].st.bipolar_mode ?
             ROWS[i].raw ^ 12'h800 : ROWS[i].raw);
    end
    i_host_model.drive(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    chk_val("data released", NONE_OE, data_oe);
    i_host_model.drive(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    chk_bit("done no select", 1'b0, done_oe);
    i_host_model.drive(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    chk_bit("done no enable", 1'b0, done_oe);
    i_host_model.set_straps(4'b0011);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    i_host_model.drive(1'b1, 1'b1, 1'b0, 1'b0);
    conv(0);
    rd_chk(IRQ_STAT_OFS, 32'h0);
    i_host_model.set_straps(4'b0010);
    conv(1);
    chk_bit("async done", 1'b0, done_oe);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    axi_wr(CTRL_OFS, 32'h0, resp_v);
    conv(0);
    rd_chk(IRQ_STAT_OFS, 32'h0);
    axi_wr(CTRL_OFS, 32'h1, resp_v);
    axi_wr(IRQ_MASK_OFS, 32'h1, resp_v);
    conv(1);
    chk_bit("irq set", 1'b1, irq);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk_bit("irq cleared", 1'b0, irq);
    // start edge while busy: overrun only, done stays masked
    axi_wr(IRQ_MASK_OFS, 32'h2, resp_v);
    i_host_model.pulse_start();
    repeat (2) @(posedge aclk);
    i_host_model.pulse_start();
    repeat (CV_C + 8) @(posedge aclk);
    chk_bit("irq overrun", 1'b1, irq);
    rd_chk(IRQ_STAT_OFS, 32'h3);
    conv(1);
    chk_bit("irq masked", 1'b0, irq);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    // soft start: one conversion, the bit reads back as zero
    axi_wr(CTRL_OFS, 32'h3, resp_v);
    chk_val("soft write resp", RESP_OKAY, resp_v);
    repeat (CV_C + 4) @(posedge aclk);
    rd_chk(IRQ_STAT_OFS, 32'h1);
    rd_chk(CTRL_OFS, 32'h1);
    rd_chk(STATUS_OFS, 32'h20);
    axi_rd(8'h40, rd_v, resp_v);
    chk_val("unmapped read resp", RESP_SLVERR, resp_v);
    chk_val("unmapped read data", 32'h0, rd_v);
    axi_wr(8'h40, 32'h1, resp_v);
    chk_val("unmapped write", RESP_SLVERR, resp_v);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(IRQ_MASK_OFS, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
